//--- hdl/midi_pkg.sv
// constants, field positions and state types of the serial music port
package midi_pkg;

	// ------------------------------------------------------------
	// host register offsets
	// ------------------------------------------------------------
	localparam logic [1:0] OFS_DATA = 2'h0;
	localparam logic [1:0] OFS_STAT = 2'h1;
	localparam logic [1:0] OFS_CTRL = 2'h2;

	// ------------------------------------------------------------
	// port_status bit positions
	// ------------------------------------------------------------
	localparam int ST_RX_EMPTY = 7;
	localparam int ST_TX_FULL  = 6;
	localparam int ST_RX_FULL  = 5;
	localparam int ST_MODE     = 4;
	localparam int ST_OVERRUN  = 3;
	localparam int ST_TX_AVAIL = 2;

	// ------------------------------------------------------------
	// enhanced_control bit positions and reset value
	// ------------------------------------------------------------
	localparam int CT_LOOP     = 7;
	localparam int CT_THRU     = 6;
	localparam int CT_PT_TX    = 4;
	localparam int CT_RX_IE    = 3;
	localparam int CT_MASK     = 2;
	localparam int CT_TX_IE    = 1;
	localparam int CT_RX_FIFO  = 0;
	localparam logic [7:0] CTRL_RESET = 8'h09;
	localparam logic [7:0] CTRL_WMASK = 8'hDF;

	// ------------------------------------------------------------
	// command codes and replies
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_UART  = 8'h3F;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] ACK_BYTE  = 8'hFE;

	// ------------------------------------------------------------
	// serial timing: 31.25 kbaud at 125 MHz
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int BIT_TIME_NS   = 32000;
	localparam int BIT_CYC       = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int CNT_W         = 12;
	localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYC - 1);
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_CYC / 2 - 1);
	localparam logic [3:0] FRAME_BITS = 4'hA;
	localparam logic [3:0] DATA_BITS  = 4'h8;

	// ------------------------------------------------------------
	// buffering
	// ------------------------------------------------------------
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} rx_state_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} tx_state_t;

endpackage

//--- hdl/byte_fifo.sv
// first-in first-out buffer with valid/ready on both sides and a flush
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic                     clk_i,
	input  wire logic                     srst_i,
	input  wire logic                     flush_i,
	input  wire logic                     in_valid_i,
	output logic                          in_ready_o,
	input  wire logic [WIDTH-1:0]         in_data_i,
	output logic                          out_valid_o,
	input  wire logic                     out_ready_i,
	output logic [WIDTH-1:0]              out_data_o,
	output logic [$clog2(DEPTH):0]        level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q, wr_d;
	logic [AW:0]      rd_q, rd_d;
	logic             push;
	logic             pop;

	// ------------------------------------------------------------
	// flags: pointers carry one extra wrap bit
	// ------------------------------------------------------------
	assign level_o     = wr_q - rd_q;
	assign in_ready_o  = (level_o != (AW+1)'(DEPTH));
	assign out_valid_o = (wr_q != rd_q);
	assign out_data_o  = mem[rd_q[AW-1:0]];
	assign push        = in_valid_i & in_ready_o & ~flush_i;
	assign pop         = out_valid_o & out_ready_i & ~flush_i;

	// next pointers; flush drops everything stored
	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		if (flush_i) begin
			wr_d = '0;
			rd_d = '0;
		end else begin
			if (push)
				wr_d = wr_q + 1'b1;
			if (pop)
				rd_d = rd_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// storage needs no reset; only pointers matter
	always_ff @(posedge clk_i) begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data_i;
	end

endmodule

//--- hdl/midi_port.sv
// serial music port: host registers, receive and transmit engines, routing
//
// Function
// - data read pops received byte or reply
// - data write queues byte for transmit
// - offset one: write command, read status
// - status bit7 receive empty, resets high
// - status bit6 transmit side full
// - status bit5 receive fifo full, zero disabled
// - status bit4 shows uart mode
// - status bit3 overrun, cleared by status read
// - status bit2 transmit fifo holds data, zero disabled
// - control bit7 loops transmit into receive
// - control bit6 mirrors receive pin out
// - control bit4 allows pass-through transmit
// - control bit3 enables receive interrupt
// - control bit2 holds transmit pin high
// - control bit1 enables transmit-empty interrupt
// - control bit0 enables receive and transmit fifos in pass-through
// - command FFh resets port to pass-through
// - command 3Fh enters uart, acknowledges FEh
// - overrun keeps old data, drops new
module midi_port
	import midi_pkg::*;
#(
	parameter int DEPTH = midi_pkg::FIFO_DEPTH
) (
	input  wire logic                     clk_i,
	input  wire logic                     srst_i,
	input  wire logic [1:0]               addr_i,
	input  wire logic                     rd_i,
	input  wire logic                     wr_i,
	input  wire logic [midi_pkg::DATA_W-1:0] wdata_i,
	output logic [midi_pkg::DATA_W-1:0]   rdata_o,
	output logic                          irq_o,
	input  wire logic                     serial_rx_pin_i,
	output logic                          serial_tx_pin_o
);
	import midi_pkg::*;

	localparam int LW = $clog2(DEPTH) + 1;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic              rx_s1_q;
	logic              rx_s2_q;
	logic              rx_line;
	logic              tx_line;

	logic [7:0]        ctrl_q, ctrl_d;
	logic              mode_q, mode_d;
	logic              ovr_q, ovr_d;
	logic              ack_q, ack_d;
	logic [7:0]        rdata_q, rdata_d;
	logic              irq_q, irq_d;
	logic              pin_q, pin_d;
	logic              flush;

	rx_state_t         rx_st_q, rx_st_d;
	logic [CNT_W-1:0]  rx_cnt_q, rx_cnt_d;
	logic [3:0]        rx_bit_q, rx_bit_d;
	logic [7:0]        rx_sh_q, rx_sh_d;
	logic              rx_done_q, rx_done_d;

	tx_state_t         tx_st_q, tx_st_d;
	logic [CNT_W-1:0]  tx_cnt_q, tx_cnt_d;
	logic [3:0]        tx_bit_q, tx_bit_d;
	logic [9:0]        tx_sh_q, tx_sh_d;

	logic              fifo_en;
	logic              tx_en;
	logic              rd_data;
	logic              rd_stat;
	logic              wr_data;
	logic              wr_cmd;
	logic              wr_ctrl;

	logic              rxf_in_valid;
	logic              rxf_in_ready;
	logic [7:0]        rxf_in_data;
	logic              rxf_valid;
	logic              rxf_pop;
	logic [7:0]        rxf_data;
	logic [LW-1:0]     rxf_level;
	logic              rx_full;

	logic              txf_push;
	logic              txf_in_ready;
	logic              txf_valid;
	logic              txf_pop;
	logic [7:0]        txf_data;
	logic [LW-1:0]     txf_level;
	logic              tx_full;

	logic [7:0]        status;

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------

	// two flops before anything looks at the receive pin
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_rx_pin_i;
			rx_s2_q <= rx_s1_q;
		end
	end

	// ------------------------------------------------------------
	// host access decode and capacity
	// ------------------------------------------------------------
	assign rd_data = rd_i & (addr_i == OFS_DATA);
	assign rd_stat = rd_i & (addr_i == OFS_STAT);
	assign wr_data = wr_i & (addr_i == OFS_DATA);
	assign wr_cmd  = wr_i & (addr_i == OFS_STAT);
	assign wr_ctrl = wr_i & (addr_i == OFS_CTRL);

	// uart mode always buffers; pass-through only if asked
	assign fifo_en = mode_q | ctrl_q[CT_RX_FIFO];
	// pass-through sends only when the host allows it
	assign tx_en   = mode_q | ctrl_q[CT_PT_TX];

	// without fifos each side holds a single byte
	assign rx_full = fifo_en ? ~rxf_in_ready : (rxf_level != '0);
	assign tx_full = fifo_en ? ~txf_in_ready : (txf_level != '0);

	// loopback feeds our own transmit line into the receiver
	assign rx_line = ctrl_q[CT_LOOP] ? tx_line : rx_s2_q;
	assign tx_line = tx_sh_q[0];

	// ------------------------------------------------------------
	// receive fifo: engine bytes win over acknowledges
	// ------------------------------------------------------------
	assign rxf_in_valid = (rx_done_q | ack_q) & ~rx_full;
	assign rxf_in_data  = rx_done_q ? rx_sh_q : ACK_BYTE;
	assign rxf_pop      = rd_data;

	byte_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) rx_fifo (
		.clk_i       (clk_i),
		.srst_i      (srst_i),
		.flush_i     (flush),
		.in_valid_i  (rxf_in_valid),
		.in_ready_o  (rxf_in_ready),
		.in_data_i   (rxf_in_data),
		.out_valid_o (rxf_valid),
		.out_ready_i (rxf_pop),
		.out_data_o  (rxf_data),
		.level_o     (rxf_level)
	);

	// ------------------------------------------------------------
	// transmit fifo: engine drains it and stalls while busy
	// ------------------------------------------------------------
	assign txf_push = wr_data & ~tx_full;
	assign txf_pop  = (tx_st_q == TX_IDLE) & tx_en;

	byte_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) tx_fifo (
		.clk_i       (clk_i),
		.srst_i      (srst_i),
		.flush_i     (flush),
		.in_valid_i  (txf_push),
		.in_ready_o  (txf_in_ready),
		.in_data_i   (wdata_i),
		.out_valid_o (txf_valid),
		.out_ready_i (txf_pop),
		.out_data_o  (txf_data),
		.level_o     (txf_level)
	);

	// ------------------------------------------------------------
	// status byte
	// ------------------------------------------------------------
	always_comb begin
		status              = 8'h00;
		status[ST_RX_EMPTY] = ~rxf_valid;
		status[ST_TX_FULL]  = tx_full;
		status[ST_RX_FULL]  = fifo_en & ~rxf_in_ready;
		status[ST_MODE]     = mode_q;
		status[ST_OVERRUN]  = ovr_q;
		status[ST_TX_AVAIL] = fifo_en & txf_valid;
	end

	// ------------------------------------------------------------
	// host registers, commands and outputs
	// ------------------------------------------------------------

	// a reset command empties both buffers at once
	assign flush = wr_cmd & (wdata_i == CMD_RESET);

	always_comb begin
		ctrl_d  = ctrl_q;
		mode_d  = mode_q;
		ack_d   = ack_q;
		ovr_d   = ovr_q;
		rdata_d = rdata_q;
		// acknowledge leaves once written or dropped
		if (ack_q & ~rx_done_q)
			ack_d = 1'b0;
		if (wr_ctrl)
			ctrl_d = wdata_i & CTRL_WMASK;
		if (wr_cmd) begin
			if (wdata_i == CMD_RESET) begin
				mode_d = 1'b0;
				ovr_d  = 1'b0;
				ack_d  = ~mode_q;
			end else if (~mode_q) begin
				// every pass-through command is acknowledged
				ack_d  = 1'b1;
				if (wdata_i == CMD_UART)
					mode_d = 1'b1;
			end
		end
		// status read clears, but a new overrun wins
		if (rd_stat)
			ovr_d = 1'b0;
		if ((rx_done_q & rx_full) | (ack_q & ~rx_done_q & rx_full))
			ovr_d = 1'b1;
		if (rd_data)
			rdata_d = rxf_valid ? rxf_data : 8'h00;
		else if (rd_stat)
			rdata_d = status;
		else if (rd_i & (addr_i == OFS_CTRL))
			rdata_d = ctrl_q;
		else if (rd_i)
			rdata_d = 8'h00;
	end

	// interrupt and pin are registered so outputs never glitch
	always_comb begin
		irq_d = (ctrl_q[CT_RX_IE] & rxf_valid)
			| (ctrl_q[CT_TX_IE] & ~txf_valid);
		if (ctrl_q[CT_MASK])
			pin_d = 1'b1;
		else if (ctrl_q[CT_THRU])
			pin_d = rx_s2_q;
		else
			pin_d = tx_line;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_q  <= CTRL_RESET;
			mode_q  <= 1'b0;
			ovr_q   <= 1'b0;
			ack_q   <= 1'b0;
			rdata_q <= 8'h00;
			irq_q   <= 1'b0;
			pin_q   <= 1'b1;
		end else begin
			ctrl_q  <= ctrl_d;
			mode_q  <= mode_d;
			ovr_q   <= ovr_d;
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
			pin_q   <= pin_d;
		end
	end

	assign rdata_o         = rdata_q;
	assign irq_o           = irq_q;
	assign serial_tx_pin_o = pin_q;

	// ------------------------------------------------------------
	// receive engine: start bit checked at mid-bit
	// ------------------------------------------------------------
	always_comb begin
		rx_st_d   = rx_st_q;
		rx_cnt_d  = rx_cnt_q;
		rx_bit_d  = rx_bit_q;
		rx_sh_d   = rx_sh_q;
		rx_done_d = 1'b0;
		case (rx_st_q)
			RX_IDLE: begin
				if (~rx_line) begin
					rx_st_d  = RX_START;
					rx_cnt_d = HALF_LAST;
				end
			end
			RX_START: begin
				if (rx_cnt_q != '0)
					rx_cnt_d = rx_cnt_q - 1'b1;
				else if (rx_line)
					rx_st_d = RX_IDLE;  // glitch, not a start bit
				else begin
					rx_st_d  = RX_DATA;
					rx_cnt_d = BIT_LAST;
					rx_bit_d = 4'h0;
				end
			end
			RX_DATA: begin
				if (rx_cnt_q != '0)
					rx_cnt_d = rx_cnt_q - 1'b1;
				else begin
					rx_sh_d  = {rx_line, rx_sh_q[7:1]};
					rx_bit_d = rx_bit_q + 1'b1;
					rx_cnt_d = BIT_LAST;
					if (rx_bit_q == DATA_BITS - 4'h1)
						rx_st_d = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_cnt_q != '0)
					rx_cnt_d = rx_cnt_q - 1'b1;
				else begin
					// framing errors are dropped silently
					rx_done_d = rx_line;
					rx_st_d   = RX_IDLE;
				end
			end
			default: rx_st_d = RX_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_st_q   <= RX_IDLE;
			rx_cnt_q  <= '0;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= 8'h00;
			rx_done_q <= 1'b0;
		end else begin
			rx_st_q   <= rx_st_d;
			rx_cnt_q  <= rx_cnt_d;
			rx_bit_q  <= rx_bit_d;
			rx_sh_q   <= rx_sh_d;
			rx_done_q <= rx_done_d;
		end
	end

	// ------------------------------------------------------------
	// transmit engine: one start, eight data, one stop
	// ------------------------------------------------------------
	always_comb begin
		tx_st_d  = tx_st_q;
		tx_cnt_d = tx_cnt_q;
		tx_bit_d = tx_bit_q;
		tx_sh_d  = tx_sh_q;
		case (tx_st_q)
			TX_IDLE: begin
				if (txf_pop & txf_valid) begin
					tx_st_d  = TX_SEND;
					tx_sh_d  = {1'b1, txf_data, 1'b0};
					tx_cnt_d = BIT_LAST;
					tx_bit_d = 4'h0;
				end
			end
			TX_SEND: begin
				if (tx_cnt_q != '0)
					tx_cnt_d = tx_cnt_q - 1'b1;
				else begin
					tx_sh_d  = {1'b1, tx_sh_q[9:1]};
					tx_cnt_d = BIT_LAST;
					tx_bit_d = tx_bit_q + 1'b1;
					if (tx_bit_q == FRAME_BITS - 4'h1)
						tx_st_d = TX_IDLE;
				end
			end
			default: tx_st_d = TX_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tx_st_q  <= TX_IDLE;
			tx_cnt_q <= '0;
			tx_bit_q <= 4'h0;
			tx_sh_q  <= 10'h3FF;
		end else begin
			tx_st_q  <= tx_st_d;
			tx_cnt_q <= tx_cnt_d;
			tx_bit_q <= tx_bit_d;
			tx_sh_q  <= tx_sh_d;
		end
	end

endmodule

//--- sim/midi_port_chk.sv
// assertion checker for the serial music port registers and pins
module midi_port_chk
	import midi_pkg::*;
#(
	parameter int DEPTH = 8
) (
	input  wire logic                        clk_i,
	input  wire logic                        srst_i,
	input  wire logic [1:0]                  addr_i,
	input  wire logic                        rd_i,
	input  wire logic                        wr_i,
	input  wire logic [midi_pkg::DATA_W-1:0] wdata_i,
	input  wire logic [midi_pkg::DATA_W-1:0] rdata_o,
	input  wire logic                        irq_o,
	input  wire logic                        serial_rx_pin_i,
	input  wire logic                        serial_tx_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// ------------------------------------------------------------
	// shadow control register and mirror-path stability count
	// ------------------------------------------------------------
	logic [7:0] ctl_q;
	logic [7:0] ctl_d;
	logic [2:0] stab_q;
	logic [2:0] stab_d;
	logic       rx_q;
	logic       thru;
	assign thru = ctl_q[CT_THRU] & ~ctl_q[CT_MASK];
	// count saturates so a long idle never wraps below the threshold
	always_comb begin
		ctl_d = ctl_q;
		if (wr_i && addr_i == OFS_CTRL) begin
			ctl_d = wdata_i & CTRL_WMASK;
		end
		stab_d = (thru && rx_q == serial_rx_pin_i) ? stab_q + 3'(stab_q != 3'h7) : 3'h0;
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctl_q <= CTRL_RESET;
			stab_q <= 3'h0;
			rx_q <= 1'b1;
		end else begin
			ctl_q <= ctl_d;
			stab_q <= stab_d;
			rx_q <= serial_rx_pin_i;
		end
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_rdata_hold; !rd_i |=> $stable(rdata_o); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
	property p_stat_rsvd; rd_i && addr_i == OFS_STAT |=> rdata_o[1:0] == 2'h0; endproperty
	a_stat_rsvd: assert property (p_stat_rsvd) else $error("status low bits not zero");
	property p_gap_zero; rd_i && addr_i == 2'h3 |=> rdata_o == 8'h00; endproperty
	a_gap_zero: assert property (p_gap_zero) else $error("unmapped offset not zero");
	property p_full_empty; rd_i && addr_i == OFS_STAT |=> !(rdata_o[ST_RX_FULL] && rdata_o[ST_RX_EMPTY]); endproperty
	a_full_empty: assert property (p_full_empty) else $error("receive full and empty together");
	property p_ctrl_read; rd_i && addr_i == OFS_CTRL |=> rdata_o == $past(ctl_q); endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
	sequence s_cmd_uart; wr_i && addr_i == OFS_STAT && wdata_i == CMD_UART; endsequence
	property p_uart; s_cmd_uart ##2 (rd_i && addr_i == OFS_STAT) |=> rdata_o[ST_MODE]; endproperty
	a_uart: assert property (p_uart) else $error("mode bit not set after mode command");
	property p_preset; (wr_i && addr_i == OFS_STAT && wdata_i == CMD_RESET) ##2 (rd_i && addr_i == OFS_STAT)
		|=> !rdata_o[ST_MODE] && !rdata_o[ST_TX_AVAIL]; endproperty
	a_preset: assert property (p_preset) else $error("port reset command not taken");
	property p_mask; ctl_q[CT_MASK] && $past(ctl_q[CT_MASK]) |-> serial_tx_pin_o; endproperty
	a_mask: assert property (p_mask) else $error("masked pin not high");
	// the pin lags the receive line by two synchroniser flops and the output flop
	property p_thru; stab_q >= 3'h5 |-> serial_tx_pin_o == $past(serial_rx_pin_i, 3); endproperty
	a_thru: assert property (p_thru) else $error("pin does not mirror receive line");
	c_uart: cover property (s_cmd_uart);
	c_thru: cover property (stab_q == 3'h7);
	c_irq: cover property (irq_o);
endmodule

bind midi_port midi_port_chk #(.DEPTH(DEPTH)) u_chk (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .rd_i(rd_i),
	.wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq_o), .serial_rx_pin_i(serial_rx_pin_i),
	.serial_tx_pin_o(serial_tx_pin_o));

//--- sim/midi_partner.sv
// serial music device model: sends frames on a line and decodes the other
module midi_partner (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import midi_pkg::*;
	logic [7:0] got_q[$];
	logic [7:0] sh;
	initial line_o = 1'b1;
	// start low, eight bits lsb first, stop high; idles high between frames
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			line_o = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (BIT_CYC) @(posedge clk_i);
		end
	endtask
	// mid-bit decoder; a frame with a low stop bit is dropped
	initial forever begin
		@(negedge line_i);
		repeat (BIT_CYC / 2) @(posedge clk_i);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CYC) @(posedge clk_i);
			if (i < 8) sh = {line_i, sh[7:1]};
			else if (line_i) got_q.push_back(sh);
		end
	end
endmodule

//--- sim/testbench.sv
// self-checking bench for the serial music port with register model and partner
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin err_total++; $display("FAIL %0t got %h want %h", $time, act, exp); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import midi_pkg::*;
	logic       clk_i = 1'b0;
	logic       srst_i = 1'b1;
	logic [1:0] addr_i = 2'h0;
	logic       rd_i = 1'b0;
	logic       wr_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o, v, a_b, b_b;
	logic       irq_o, rx_pin, tx_pin;
	int         err_total = 0, cmp_count = 0, seed = 37139;
	int         mode = 0, ctl = 9, txn = 0, ovr = 0, eng = 0;
	logic [7:0] rxq[$];
	always #4 clk_i = ~clk_i;

	midi_port #(.DEPTH(FIFO_DEPTH)) dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq_o), .serial_rx_pin_i(rx_pin), .serial_tx_pin_o(tx_pin));
	midi_partner peer (.clk_i(clk_i), .line_i(tx_pin), .line_o(rx_pin));

	// ------------------------------------------------------------
	// register model: each side holds one byte unless fifos are on
	// ------------------------------------------------------------
	function automatic int cap();
		return (mode || ctl[0]) ? FIFO_DEPTH : 1;
	endfunction
	function automatic logic [7:0] stat();
		int f;
		f = mode | (ctl & 1);
		return {rxq.size() == 0, txn >= cap(), f && rxq.size() >= cap(), mode[0], ovr[0], f && txn > 0, 2'b00};
	endfunction

	// ------------------------------------------------------------
	// bus cycles: one-cycle strobes, a free cycle between accesses
	// ------------------------------------------------------------
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i) #1;
		addr_i = a;
		wdata_i = d;
		wr_i = 1'b1;
		@(posedge clk_i) #1;
		wr_i = 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_i) #1;
		addr_i = a;
		rd_i = 1'b1;
		@(posedge clk_i) #1;
		rd_i = 1'b0;
		d = rdata_o;
	endtask
	task automatic setctl(input logic [7:0] d);
		wr(OFS_CTRL, d);
		ctl = d & 8'hDF;
	endtask
	// peek reads status two cycles after the command, once any reply has landed
	task automatic cmd(input logic [7:0] c, input int peek);
		wr(OFS_STAT, c);
		if (peek) rd(OFS_STAT, v);
		if (c == CMD_RESET) begin
			rxq.delete();
			txn = 0;
			ovr = 0;
		end
		if (mode == 0) begin
			if (rxq.size() < cap()) rxq.push_back(ACK_BYTE);
			else ovr = 1;
			if (c == CMD_UART) mode = 1;
		end else if (c == CMD_RESET) begin
			mode = 0;
		end
		repeat (3) @(posedge clk_i);
	endtask
	task automatic put(input logic [7:0] d);
		wr(OFS_DATA, d);
		if ((mode || ctl[4]) && !eng) eng = 1;
		else if (txn < cap()) txn++;
	endtask
	task automatic chk_stat();
		rd(OFS_STAT, v);
		`CHK(v, stat())
		ovr = 0;
		`CHK(irq_o, ((ctl[3] && rxq.size() > 0) || (ctl[1] && txn == 0)))
	endtask
	task automatic chk_data();
		logic [7:0] e;
		e = (rxq.size() > 0) ? rxq.pop_front() : 8'h00;
		rd(OFS_DATA, v);
		`CHK(v, e)
	endtask
	task automatic end_sim();
		if (err_total == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		#1 srst_i = 1'b0;
		chk_stat();
		rd(OFS_CTRL, v);
		`CHK(v, 8'h09)
		rd(2'h3, v);
		`CHK(v, 8'h00)
		chk_data();
		v = $random(seed);
		setctl(v | 8'h20);
		rd(OFS_CTRL, v);
		`CHK(v, ctl[7:0])
		setctl(8'h49);
		for (int i = 0; i < FIFO_DEPTH + 1; i++) cmd(8'h00, 0);
		chk_stat();
		chk_stat();
		repeat (FIFO_DEPTH) chk_data();
		chk_stat();
		// incoming frame with the mirror path on
		a_b = $random(seed);
		peer.send(a_b);
		rxq.push_back(a_b);
		repeat (100) @(posedge clk_i);
		`CHK(peer.got_q[0], a_b)
		chk_stat();
		chk_data();
		put(8'h5A);
		chk_stat();
		cmd(CMD_RESET, 1);
		chk_stat();
		chk_data();
		// uart mode, looped back with the pin masked, transmit side filled
		cmd(CMD_UART, 1);
		chk_data();
		chk_stat();
		setctl(8'h86);
		b_b = $random(seed);
		for (int i = 0; i < FIFO_DEPTH + 2; i++) put(i == 0 ? b_b : 8'(i));
		chk_stat();
		cmd(CMD_RESET, 1);
		chk_stat();
		repeat (10 * BIT_CYC) @(posedge clk_i);
		rxq.push_back(b_b);
		chk_stat();
		chk_data();
		`CHK(peer.got_q.size() == 1, 1'b1)
		end_sim();
	end

	// hang guard: both frames fit well inside this span
	initial begin
		repeat (100000) @(posedge clk_i);
		err_total++;
		end_sim();
	end
endmodule
